// ==== rtl/acs_consts.svh ====
// Constants for the conversion sequencer: mode codes, counts and timing
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// ----------------------------------------------------------------------
// Mode select codes
// ----------------------------------------------------------------------
`define ACS_MODE_SINGLE 2'h0
`define ACS_MODE_MULTI 2'h1
`define ACS_MODE_CONT 2'h2
`define ACS_MODE_TURBO 2'h3

// ----------------------------------------------------------------------
// Decimator pipeline and resolution
// ----------------------------------------------------------------------
`define ACS_PRIME_CONV 3
`define ACS_PIPE_DEPTH 4
`define ACS_RES_HI_BITS 12
`define ACS_RES_LO_BITS 8
`define ACS_RATE_HI_KSPS 192
`define ACS_RATE_LO_KSPS 384
`define ACS_CLK_MHZ 200

// ----------------------------------------------------------------------
// Clock cycles per conversion, each period rounded down
// ----------------------------------------------------------------------
`define ACS_CYC_HI ((`ACS_CLK_MHZ * 1000) / `ACS_RATE_HI_KSPS)
`define ACS_CYC_LO ((`ACS_CLK_MHZ * 1000) / `ACS_RATE_LO_KSPS)

`endif

// ==== rtl/acs_decimator.sv ====
// Four-tap decimator: result is the sum of the four latest modulator samples
`timescale 1ns/1ps
`include "acs_consts.svh"

module acs_decimator #(
    parameter int DATA_W = `ACS_RES_HI_BITS,
    parameter int DEPTH = `ACS_PIPE_DEPTH
) (
    input wire logic clk,
    input wire logic rstSync_n,
    input wire logic clear,
    input wire logic sampleStrobe,
    input wire logic [DATA_W-1:0] sampleIn,
    output logic [DATA_W-1:0] sumOut,
    output logic primed
);

    logic [DATA_W-1:0] tap_reg [DEPTH];
    logic [DATA_W-1:0] tap_next [DEPTH];
    logic [2:0] fill_reg;
    logic [2:0] fill_next;
    logic [DATA_W-1:0] acc;

    // ------------------------------------------------------------------
    // Shift and fill count
    // ------------------------------------------------------------------
    // Clear wipes history so an earlier input cannot leak into a result
    always_comb begin
        tap_next = tap_reg;
        fill_next = fill_reg;
        if (clear) begin
            for (int i = 0; i < DEPTH; i++) begin
                tap_next[i] = '0;
            end
            fill_next = 3'h0;
        end else if (sampleStrobe) begin
            tap_next[0] = sampleIn;
            for (int i = 1; i < DEPTH; i++) begin
                tap_next[i] = tap_reg[i-1];
            end
            if (fill_reg < 3'(DEPTH)) begin
                fill_next = fill_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                tap_reg[i] <= '0;
            end
            fill_reg <= 3'h0;
        end else begin
            tap_reg <= tap_next;
            fill_reg <= fill_next;
        end
    end

    // ------------------------------------------------------------------
    // Output sum, wraps at data width
    // ------------------------------------------------------------------
    // Summed from the next taps so the sample strobed this cycle counts
    always_comb begin
        acc = '0;
        for (int i = 0; i < DEPTH; i++) begin
            acc = acc + tap_next[i];
        end
    end

    assign sumOut = acc;
    assign primed = (fill_reg == 3'(DEPTH));

endmodule // acs_decimator

// ==== rtl/acs_pkg.sv ====
// Types shared by the conversion sequencer files
package acs_pkg;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_CONVERT,
        ACS_HOLD
    } acs_state_t;

endpackage

// ==== rtl/acs_sequencer.sv ====
// Conversion sequencer: triggering, priming, modes and end-of-conversion
`timescale 1ns/1ps
`include "acs_consts.svh"

module acs_sequencer #(
    parameter int CYC_HI = `ACS_CYC_HI,
    parameter int CYC_LO = `ACS_CYC_LO
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] modeSel,
    input wire logic lowRes,
    input wire logic swStart,
    input wire logic convStart,
    input wire logic muxChange,
    input wire logic modBit,
    input wire logic resultRead,
    output logic [`ACS_RES_HI_BITS-1:0] result,
    output logic resultValid,
    output logic statusDone,
    output logic convDone,
    output logic busy
);

    localparam int RW = `ACS_RES_HI_BITS;

    // ------------------------------------------------------------------
    // Reset release and start pin synchroniser
    // ------------------------------------------------------------------
    logic rstA_reg, rstB_reg, rstSync_n;
    logic [2:0] startSync_reg;
    logic startSeen_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstA_reg <= 1'b0;
            rstB_reg <= 1'b0;
        end else begin
            rstA_reg <= 1'b1;
            rstB_reg <= rstA_reg;
        end
    end
    assign rstSync_n = rstB_reg;

    logic [2:0] startSync_next;
    logic startSeen_next;
    // Pin is asynchronous; a change counts once stages two and three agree
    always_comb begin
        startSync_next = {startSync_reg[1:0], convStart};
        startSeen_next = startSeen_reg;
        if (startSync_reg[1] == startSync_reg[2]) begin
            startSeen_next = startSync_reg[2];
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            startSync_reg <= 3'h0;
            startSeen_reg <= 1'b0;
        end else begin
            startSync_reg <= startSync_next;
            startSeen_reg <= startSeen_next;
        end
    end

    // Rising edge; a floating-low pin never fires, so continuous still runs
    logic startEdge;
    assign startEdge = startSeen_next & ~startSeen_reg;

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    acs_pkg::acs_state_t state_reg, state_next;
    logic [15:0] cyc_reg, cyc_next;
    logic [2:0] conv_reg, conv_next;
    logic [RW-1:0] sample_reg, sample_next;
    logic [RW-1:0] result_reg, result_next;
    logic done_reg, done_next;
    logic valid_reg, valid_next;
    logic [2:0] since_reg, since_next;
    logic [1:0] modeRun_reg, modeRun_next;
    logic lowRun_reg, lowRun_next;

    logic trig;
    logic periodEnd;
    logic decClear;
    logic [RW-1:0] decSum;
    logic [RW-1:0] sampleFull;
    logic [15:0] cycLimit;
    logic repeatMode;

    assign trig = swStart | startEdge;
    assign sampleFull = sample_reg + RW'(modBit);
    assign cycLimit = lowRun_reg ? 16'(CYC_LO - 1) : 16'(CYC_HI - 1);
    assign periodEnd = (state_reg == acs_pkg::ACS_CONVERT) && (cyc_reg == cycLimit);
    // Multi and turbo restart automatically, continuous free-runs
    assign repeatMode = (modeRun_reg != `ACS_MODE_SINGLE);

    // Each new sample in multi/turbo starts from a wiped decimator
    assign decClear = muxChange | (state_reg != acs_pkg::ACS_CONVERT);

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cyc_next = cyc_reg;
        conv_next = conv_reg;
        sample_next = sample_reg;
        result_next = result_reg;
        done_next = done_reg;
        valid_next = valid_reg;
        since_next = since_reg;
        modeRun_next = modeRun_reg;
        lowRun_next = lowRun_reg;

        // Modulator bits accumulate into one conversion sample
        if (state_reg == acs_pkg::ACS_CONVERT) begin
            sample_next = sampleFull;
            cyc_next = cyc_reg + 16'h1;
        end

        // Input switch: results invalid until four more samples
        if (muxChange) begin
            since_next = 3'h0;
            valid_next = 1'b0;
        end

        unique case (state_reg)
            acs_pkg::ACS_IDLE: begin
                // Standby: nothing converts until a trigger
                if (trig) begin
                    state_next = acs_pkg::ACS_CONVERT;
                    modeRun_next = modeSel;
                    lowRun_next = lowRes;
                    cyc_next = 16'h0;
                    conv_next = 3'h0;
                    sample_next = '0;
                end
            end
            acs_pkg::ACS_CONVERT: begin
                if (periodEnd) begin
                    cyc_next = 16'h0;
                    sample_next = '0;
                    if (!muxChange && since_reg < 3'(`ACS_PIPE_DEPTH)) begin
                        since_next = since_reg + 3'h1;
                    end
                    if (conv_reg < 3'(`ACS_PRIME_CONV)) begin
                        conv_next = conv_reg + 3'h1;
                    end else begin
                        // Fourth conversion: result ready
                        result_next = lowRun_reg ?
                            {decSum[RW-1 -: `ACS_RES_LO_BITS], 4'h0} : decSum;
                        done_next = 1'b1;
                        valid_next = !muxChange && (since_reg >= 3'(`ACS_PIPE_DEPTH - 1));
                        if (modeRun_reg == `ACS_MODE_CONT) begin
                            conv_next = 3'(`ACS_PRIME_CONV);
                        end else if (repeatMode) begin
                            state_next = acs_pkg::ACS_HOLD;
                            conv_next = 3'h0;
                        end else begin
                            state_next = acs_pkg::ACS_HOLD;
                        end
                    end
                end
            end
            acs_pkg::ACS_HOLD: begin
                // One idle cycle resets the decimator between samples
                if (repeatMode) begin
                    state_next = acs_pkg::ACS_CONVERT;
                    conv_next = 3'h0;
                    cyc_next = 16'h0;
                end else if (resultRead || !done_reg) begin
                    state_next = acs_pkg::ACS_IDLE;
                end
            end
            default: begin
                state_next = acs_pkg::ACS_IDLE;
            end
        endcase

        // Read clears done unless a new result lands this cycle
        if (resultRead && !(periodEnd && conv_reg >= 3'(`ACS_PRIME_CONV))) begin
            done_next = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_reg <= acs_pkg::ACS_IDLE;
            cyc_reg <= 16'h0;
            conv_reg <= 3'h0;
            sample_reg <= '0;
            result_reg <= '0;
            done_reg <= 1'b0;
            valid_reg <= 1'b0;
            since_reg <= 3'(`ACS_PIPE_DEPTH);
            modeRun_reg <= `ACS_MODE_SINGLE;
            lowRun_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cyc_reg <= cyc_next;
            conv_reg <= conv_next;
            sample_reg <= sample_next;
            result_reg <= result_next;
            done_reg <= done_next;
            valid_reg <= valid_next;
            since_reg <= since_next;
            modeRun_reg <= modeRun_next;
            lowRun_reg <= lowRun_next;
        end
    end

    // ------------------------------------------------------------------
    // Decimator
    // ------------------------------------------------------------------
    acs_decimator #(
        .DATA_W(RW),
        .DEPTH(`ACS_PIPE_DEPTH)
    ) uDecimator (
        .clk(clk),
        .rstSync_n(rstSync_n),
        .clear(decClear),
        .sampleStrobe(periodEnd),
        .sampleIn(sampleFull),
        .sumOut(decSum),
        .primed()
    );

    // ------------------------------------------------------------------
    // Outputs; status and pin share one flop so they clear together
    // ------------------------------------------------------------------
    assign result = result_reg;
    assign resultValid = valid_reg;
    assign statusDone = done_reg;
    assign convDone = done_reg;
    assign busy = (state_reg != acs_pkg::ACS_IDLE);

endmodule // acs_sequencer

// ==== tb/acs_host_model.sv ====
// Host model: CPU or DMA that waits for a result and reads it
`timescale 1ns/1ps
module acs_host_model (
    input wire logic clk,
    input wire logic pollMode,
    input wire logic [2:0] readDelay,
    input wire logic statusDone,
    input wire logic convDone,
    output logic resultRead
);
    // Poll status or follow done line; recheck so no read lands on nothing
    initial begin
        resultRead = 1'b0;
        forever begin
            @(negedge clk);
            if ((pollMode ? statusDone : convDone) === 1'b1) begin
                repeat (readDelay) @(negedge clk);
                resultRead = statusDone;
                @(negedge clk);
                resultRead = 1'b0;
                @(negedge clk);
            end
        end
    end
endmodule // acs_host_model

// ==== tb/acs_sequencer_chk.sv ====
// Port checker for the conversion sequencer
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_sequencer_chk #(
    parameter int CYC_HI = `ACS_CYC_HI,
    parameter int CYC_LO = `ACS_CYC_LO
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] modeSel,
    input wire logic lowRes,
    input wire logic swStart,
    input wire logic convStart,
    input wire logic muxChange,
    input wire logic modBit,
    input wire logic resultRead,
    input wire logic [`ACS_RES_HI_BITS-1:0] result,
    input wire logic resultValid,
    input wire logic statusDone,
    input wire logic convDone,
    input wire logic busy
);
    localparam int SEQ_MAX = 4 * CYC_HI + 2;
    localparam int PER_MAX = CYC_HI + 1;
    logic [15:0] busyCyc_reg;
    logic [15:0] busyCyc_next;
    logic [15:0] seqLen;
    logic single;
    logic doneLast_reg;
    logic gapRun_reg, gapRun_next;
    logic [15:0] gapCyc_reg, gapCyc_next;
    // ----
    // Busy time since idle, so priming length can be judged
    // ----
    always_comb begin
        busyCyc_next = busy ? busyCyc_reg + 16'h0001 : 16'h0000;
        seqLen = lowRes ? 16'(4 * CYC_LO) : 16'(4 * CYC_HI);
        single = (modeSel == `ACS_MODE_SINGLE);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busyCyc_reg <= 16'h0000;
        end else begin
            busyCyc_reg <= busyCyc_next;
        end
    end
    // ----
    // Cycles since done was read; a counter keeps long periods cheap
    // ----
    always_comb begin
        gapRun_next = gapRun_reg;
        gapCyc_next = gapCyc_reg;
        if (statusDone) begin
            gapRun_next = 1'b0;
            gapCyc_next = 16'h0000;
        end else if (doneLast_reg) begin
            gapRun_next = 1'b1;
            gapCyc_next = 16'h0001;
        end else if (gapRun_reg && gapCyc_reg != 16'hFFFF) begin
            gapCyc_next = gapCyc_reg + 16'h0001;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            doneLast_reg <= 1'b0;
            gapRun_reg <= 1'b0;
            gapCyc_reg <= 16'h0000;
        end else begin
            doneLast_reg <= statusDone;
            gapRun_reg <= gapRun_next;
            gapCyc_reg <= gapCyc_next;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_start_goes_busy: assert property (!busy && swStart |=> busy)
        else $error("start not taken");
    a_done_flag_twin: assert property (convDone == statusDone)
        else $error("done output and status differ");
    a_done_holds: assert property (statusDone && !resultRead |=> statusDone)
        else $error("done dropped before read");
    a_read_clears: assert property (single && statusDone && resultRead |=> !statusDone)
        else $error("read did not clear done");
    a_single_standby: assert property (single && statusDone && resultRead |-> ##[1:2] !busy)
        else $error("no return to standby");
    a_result_holds: assert property (single && statusDone && !resultRead |=> $stable(result))
        else $error("result moved before read");
    a_done_needs_busy: assert property ($rose(convDone) |-> $past(busy))
        else $error("done while in standby");
    a_prime_count: assert property (single && $rose(convDone)
        |-> busyCyc_reg + 16'h0002 >= seqLen && busyCyc_reg <= seqLen + 16'h0002)
        else $error("result not after fourth conversion");
    a_cont_repeat: assert property (modeSel == `ACS_MODE_CONT && gapRun_reg
        |-> gapCyc_reg <= 16'(PER_MAX))
        else $error("continuous result missing");
    a_multi_repeat: assert property (modeSel[0] && gapRun_reg
        |-> gapCyc_reg <= 16'(SEQ_MAX))
        else $error("next sample not started");
    c_single: cover property (single && $rose(convDone));
    c_cont: cover property (modeSel == `ACS_MODE_CONT && $fell(statusDone));
    c_multi: cover property (modeSel[0] && $fell(statusDone));
endmodule // acs_sequencer_chk

bind acs_sequencer acs_sequencer_chk #(.CYC_HI(CYC_HI), .CYC_LO(CYC_LO)) u_acs_sequencer_chk (
    .clk(clk), .rst_n(rst_n), .modeSel(modeSel), .lowRes(lowRes), .swStart(swStart),
    .convStart(convStart), .muxChange(muxChange), .modBit(modBit), .resultRead(resultRead),
    .result(result), .resultValid(resultValid), .statusDone(statusDone),
    .convDone(convDone), .busy(busy));

// ==== tb/acs_sequencer_tb_top.sv ====
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_sequencer_tb_top;
    localparam int P_HI = 41;
    localparam int P_LO = 21;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] modeSel = `ACS_MODE_SINGLE;
    logic lowRes = 1'b0, swStart = 1'b0, convStart = 1'b0, muxChange = 1'b0, modBit = 1'b0;
    logic pollMode = 1'b0;
    logic [2:0] readDelay = 3'h0;
    logic resultRead, resultValid, statusDone, convDone, busy;
    logic [11:0] result;
    logic [12:0] notes[$];
    logic [12:0] note;
    int errCount = 0;
    int totalChecks = 0;
    int seed = 32'hFC37;
    always #2.5 clk = ~clk;
    acs_sequencer #(.CYC_HI(P_HI), .CYC_LO(P_LO)) u_acs_sequencer (.clk(clk), .rst_n(rst_n),
        .modeSel(modeSel), .lowRes(lowRes), .swStart(swStart), .convStart(convStart),
        .muxChange(muxChange), .modBit(modBit), .resultRead(resultRead), .result(result),
        .resultValid(resultValid), .statusDone(statusDone), .convDone(convDone), .busy(busy));
    acs_host_model u_acs_host_model (.clk(clk), .pollMode(pollMode), .readDelay(readDelay),
        .statusDone(statusDone), .convDone(convDone), .resultRead(resultRead));
    // ----
    // Helpers
    // ----
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stopTest();
        if (errCount == 0 && totalChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Sum of four full periods of a constant bit; 8-bit keeps the top eight bits
    function automatic logic [11:0] expVal(input logic res);
        if (!modBit) return 12'h000;
        return res ? (12'(4 * P_LO) & 12'hFF0) : 12'(4 * P_HI);
    endfunction
    task automatic doReset(input logic [1:0] mode, input logic res);
        @(negedge clk);
        rst_n = 1'b0;
        modeSel = mode;
        lowRes = res;
        modBit = 1'($random(seed));
        pollMode = 1'($random(seed));
        readDelay = 3'($random(seed));
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    // Pin start is a held level so the synchroniser sees a clean edge
    task automatic trigger(input logic usePin);
        if (usePin) begin
            convStart = 1'b1;
            repeat (6) @(negedge clk);
            convStart = 1'b0;
        end else begin
            swStart = 1'b1;
            @(negedge clk);
            swStart = 1'b0;
        end
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (notes.size() > 0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        check("results read", 16'(notes.size()), 16'h0000);
        repeat (3) @(negedge clk);
    endtask
    // Each read takes the oldest note
    always @(posedge clk) begin
        if (resultRead === 1'b1 && statusDone === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            check("resultValid", 16'(resultValid), 16'(note[12]));
            if (note[12]) check("result", 16'(result), 16'(note[11:0]));
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        stopTest();
    end
    // ----
    // Scenarios
    // ----
    initial begin
        for (int i = 0; i < 2; i++) begin
            doReset(`ACS_MODE_SINGLE, i[0]);
            check("result idle", 16'(result), 16'h0000);
            repeat (30) @(negedge clk);
            check("done idle", 16'({busy, convDone}), 16'h0000);
            for (int j = 0; j < 2; j++) begin
                notes.push_back({1'b1, expVal(i[0])});
                trigger(i[0] ^ j[0]);
                drain();
                check("standby", 16'(busy), 16'h0000);
            end
        end
        doReset(`ACS_MODE_SINGLE, 1'b0);
        notes.push_back(13'h0000);
        trigger(1'b0);
        repeat (2 * P_HI) @(negedge clk);
        muxChange = 1'b1;
        @(negedge clk);
        muxChange = 1'b0;
        drain();
        notes.push_back({1'b1, expVal(1'b0)});
        trigger(1'b0);
        drain();
        doReset(`ACS_MODE_CONT, 1'b0);
        repeat (3) notes.push_back({1'b1, expVal(1'b0)});
        trigger(1'b0);
        drain();
        for (int m = 0; m < 2; m++) begin
            doReset(m[0] ? `ACS_MODE_TURBO : `ACS_MODE_MULTI, 1'b0);
            modBit = 1'b1;
            notes.push_back({1'b1, 12'(4 * P_HI)});
            notes.push_back(13'h1000);
            trigger(1'b0);
            for (int n = 0; n < 200 && convDone !== 1'b1; n++) @(negedge clk);
            modBit = 1'b0;
            drain();
        end
        stopTest();
    end
endmodule // acs_sequencer_tb_top
